// ### shared/dxbus_if.sv
// core-side request group between the core request ports and bus engine
`timescale 1ns/1ps
interface dxbus_if;
  import dxbus_pkg::*;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic        op_rd;
  logic        op_wr;
  logic        op_int_wr;
  modport src (output addr, output wdata, output op_rd, output op_wr, output op_int_wr);
  modport dst (input addr, input wdata, input op_rd, input op_wr, input op_int_wr);
endinterface

// ### shared/dxbus_pkg.sv
// constants and types for the external bus and system pin block
package dxbus_pkg;
  localparam int DXB_AW          = 12;
  localparam int DXB_DW          = 16;
  localparam int DXB_PW          = 3;
  localparam int DXB_CLK_DIV     = 4;
  localparam logic [11:0] DXB_PC_RST      = 12'h000;
  localparam logic [11:0] DXB_PORT_HIGH   = 12'hff8;
  localparam logic [15:0] DXB_DATA_RST    = 16'h0000;
  localparam logic [1:0]  DXB_DIV_RST     = 2'h0;
  localparam logic [1:0]  DXB_DIV_HALF    = 2'h2;

  typedef enum {DXB_IDLE, DXB_RD, DXB_WR, DXB_PWR} dxbus_state_t;

  typedef enum logic [1:0] {
    DXB_OP_NONE  = 2'h0,
    DXB_OP_READ  = 2'h1,
    DXB_OP_WRITE = 2'h2
  } dxbus_op_t;
endpackage

// ### src/dxbus_irq.sv
// interrupt and mode-pin capture stage
`timescale 1ns/1ps
module dxbus_irq
  import dxbus_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // pins
  input  wire logic i_sys_reset_in_n,
  input  wire logic i_ext_irq_n,
  input  wire logic i_nonmask_irq_mode_sel_n,
  input  wire logic i_global_irq_mask,
  input  wire logic i_irq_ack,
  // results
  output logic      o_irq_req,
  output logic      o_nmi_req,
  output logic      o_ext_prog_mem
);
  typedef struct packed {
    logic int_d;
    logic nmi_d;
    logic irq;
    logic nmi;
    logic ext_mem;
  } dxbus_irq_st_t;

  dxbus_irq_st_t st_r;
  dxbus_irq_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.int_d = i_ext_irq_n;
    st_nxt.nmi_d = i_nonmask_irq_mode_sel_n;
    // ack clears, but a new edge in the same cycle wins
    if (i_irq_ack) begin
      st_nxt.irq = 1'b0;
      st_nxt.nmi = 1'b0;
    end
    if (st_r.int_d && !i_ext_irq_n && !i_global_irq_mask && i_sys_reset_in_n) begin
      st_nxt.irq = 1'b1;
    end
    if (st_r.nmi_d && !i_nonmask_irq_mode_sel_n && i_sys_reset_in_n) begin
      st_nxt.nmi = 1'b1;
    end
    if (!i_sys_reset_in_n) begin
      st_nxt.ext_mem = !i_nonmask_irq_mode_sel_n;
      st_nxt.irq     = 1'b0;
      st_nxt.nmi     = 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{int_d: 1'b1, nmi_d: 1'b1, irq: 1'b0, nmi: 1'b0, ext_mem: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_irq_req      = st_r.irq;
  assign o_nmi_req      = st_r.nmi;
  assign o_ext_prog_mem = st_r.ext_mem;
endmodule

// ### src/dxbus_top.sv
// external memory and i/o bus with system pins
`timescale 1ns/1ps
module dxbus_top
  import dxbus_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // system pins
  input  wire logic        i_sys_reset_in_n,
  input  wire logic        i_ext_irq_n,
  input  wire logic        i_nonmask_irq_mode_sel_n,
  output logic             o_sys_clock_out,
  // core request side
  input  wire logic [11:0] i_core_addr,
  input  wire logic [15:0] i_core_wdata,
  input  wire logic        i_core_rd,
  input  wire logic        i_core_wr,
  input  wire logic        i_core_int_wr,
  input  wire logic        i_core_port,
  input  wire logic [2:0]  i_core_port_sel,
  input  wire logic        i_global_irq_mask,
  input  wire logic        i_irq_ack,
  output logic [11:0]      o_program_counter,
  output logic [15:0]      o_core_rdata,
  output logic             o_core_rvalid,
  output logic             o_irq_req,
  output logic             o_nmi_req,
  output logic             o_ext_prog_mem,
  // address pins (oe low = driven)
  output logic [11:0]      o_addr,
  output logic             o_addr_oe_n,
  // data pins (oe low = driven)
  input  wire logic [15:0] i_data,
  output logic [15:0]      o_data,
  output logic             o_data_oe_n,
  // strobes
  output logic             o_wr_strobe_n,
  output logic             o_rd_strobe_n
);
  typedef struct packed {
    dxbus_state_t fsm;
    logic [1:0]   div;
    logic         clk_out;
    logic [11:0]  pc;
    logic [11:0]  addr;
    logic         addr_oe_n;
    logic [15:0]  dout;
    logic         data_oe_n;
    logic         wr_n;
    logic         rd_n;
    logic [15:0]  rdata;
    logic         rvalid;
  } dxbus_st_t;

  dxbus_st_t st_r;
  dxbus_st_t st_nxt;
  dxbus_if   req_if ();

  // port cycles force the upper nine lines high
  function automatic logic [11:0] port_addr(input logic [2:0] sel);
    port_addr = DXB_PORT_HIGH | {9'h000, sel};
  endfunction

  assign req_if.addr      = i_core_port ? port_addr(i_core_port_sel) : i_core_addr;
  assign req_if.wdata     = i_core_wdata;
  assign req_if.op_rd     = i_core_rd;
  assign req_if.op_wr     = i_core_wr;
  assign req_if.op_int_wr = i_core_int_wr;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.div = st_r.div + 2'h1;
    st_nxt.clk_out = (st_nxt.div < DXB_DIV_HALF);
    st_nxt.addr_oe_n = 1'b0;
    case (st_r.fsm)
      DXB_IDLE: begin
        st_nxt.wr_n      = 1'b1;
        st_nxt.rd_n      = 1'b1;
        st_nxt.data_oe_n = 1'b1;
        if (req_if.op_wr) begin
          st_nxt.fsm  = DXB_WR;
          st_nxt.addr = req_if.addr;
          st_nxt.dout = req_if.wdata;
          st_nxt.wr_n      = 1'b0;
          st_nxt.data_oe_n = 1'b0;
        end else if (req_if.op_int_wr) begin
          st_nxt.fsm       = DXB_PWR;
          st_nxt.dout      = req_if.wdata;
          st_nxt.data_oe_n = 1'b0;
        end else if (req_if.op_rd) begin
          st_nxt.fsm  = DXB_RD;
          st_nxt.addr = req_if.addr;
          st_nxt.rd_n = 1'b0;
        end else begin
          st_nxt.addr = st_r.pc;
          st_nxt.pc   = st_r.pc + 12'h001;
        end
      end
      DXB_RD: begin
        // partner drives while strobe low; capture then release
        st_nxt.rdata  = i_data;
        st_nxt.rvalid = 1'b1;
        st_nxt.rd_n   = 1'b1;
        st_nxt.fsm    = DXB_IDLE;
      end
      DXB_WR, DXB_PWR: begin
        st_nxt.wr_n      = 1'b1;
        st_nxt.data_oe_n = 1'b1;
        st_nxt.fsm       = DXB_IDLE;
      end
      default: st_nxt.fsm = DXB_IDLE;
    endcase
    // reset pin holds pc zero, lines released
    if (!i_sys_reset_in_n) begin
      st_nxt.fsm       = DXB_IDLE;
      st_nxt.pc        = DXB_PC_RST;
      st_nxt.addr      = DXB_PC_RST;
      st_nxt.addr_oe_n = 1'b1;
      st_nxt.data_oe_n = 1'b1;
      st_nxt.wr_n      = 1'b1;
      st_nxt.rd_n      = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '{fsm: DXB_IDLE, div: DXB_DIV_RST, clk_out: 1'b1, pc: DXB_PC_RST,
                addr: DXB_PC_RST, addr_oe_n: 1'b1, dout: DXB_DATA_RST, data_oe_n: 1'b1,
                wr_n: 1'b1, rd_n: 1'b1, rdata: DXB_DATA_RST, rvalid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  dxbus_irq u_irq (
    .i_clock                  (i_clock),
    .i_rst                    (i_rst),
    .i_sys_reset_in_n         (i_sys_reset_in_n),
    .i_ext_irq_n              (i_ext_irq_n),
    .i_nonmask_irq_mode_sel_n (i_nonmask_irq_mode_sel_n),
    .i_global_irq_mask        (i_global_irq_mask),
    .i_irq_ack                (i_irq_ack),
    .o_irq_req                (o_irq_req),
    .o_nmi_req                (o_nmi_req),
    .o_ext_prog_mem           (o_ext_prog_mem)
  );

  assign o_sys_clock_out   = st_r.clk_out;
  assign o_program_counter = st_r.pc;
  assign o_core_rdata      = st_r.rdata;
  assign o_core_rvalid     = st_r.rvalid;
  assign o_addr            = st_r.addr;
  assign o_addr_oe_n       = st_r.addr_oe_n;
  assign o_data            = st_r.dout;
  assign o_data_oe_n       = st_r.data_oe_n;
  assign o_wr_strobe_n     = st_r.wr_n;
  assign o_rd_strobe_n     = st_r.rd_n;
endmodule

// ### test/dxbus_asserts.sv
// concurrent checks on the bus and system pin block
`timescale 1ns/1ps
module dxbus_asserts
  import dxbus_pkg::*;
(
  input wire logic        i_clock, i_rst, i_sys_reset_in_n, i_ext_irq_n, i_nonmask_irq_mode_sel_n,
  input wire logic        i_core_rd, i_core_wr, i_core_int_wr, i_core_port, i_global_irq_mask,
  input wire logic [2:0]  i_core_port_sel,
  input wire logic [15:0] i_core_wdata, i_data, o_data, o_core_rdata,
  input wire logic [11:0] o_addr, o_program_counter,
  input wire logic        o_sys_clock_out, o_core_rvalid, o_irq_req, o_nmi_req, o_ext_prog_mem,
  input wire logic        o_addr_oe_n, o_data_oe_n, o_wr_strobe_n, o_rd_strobe_n
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_data_release: assert property (
    !o_data_oe_n |-> !o_wr_strobe_n || $past(i_core_int_wr)) else $error("data bus driven outside a write");
  a_write_walk: assert property (
    !o_wr_strobe_n |-> !o_data_oe_n && $past(i_core_wr) && o_data == $past(i_core_wdata))
    else $error("write strobe without its data");
  a_read_walk: assert property (
    !o_rd_strobe_n |-> $past(i_core_rd) ##1 o_rd_strobe_n && o_core_rvalid && o_core_rdata == $past(i_data))
    else $error("read strobe not tied to the read");
  a_strobe_excl: assert property (o_rd_strobe_n || o_wr_strobe_n) else $error("both strobes low");
  a_port_addr: assert property (
    !(o_rd_strobe_n && o_wr_strobe_n) && $past(i_core_port) |-> o_addr == {9'h1ff, $past(i_core_port_sel)})
    else $error("port address wrong");
  a_sysclk_quarter: assert property (
    $rose(o_sys_clock_out) |-> o_sys_clock_out[*2] ##1 !o_sys_clock_out[*2] ##1 o_sys_clock_out)
    else $error("clock output not a quarter");
  a_reset_pin: assert property (
    !i_sys_reset_in_n |=> o_program_counter == DXB_PC_RST && o_addr_oe_n && o_wr_strobe_n && o_rd_strobe_n)
    else $error("reset pin not obeyed");
  a_addr_driven: assert property (
    !$past(i_rst) && i_sys_reset_in_n && $past(i_sys_reset_in_n) |-> !o_addr_oe_n)
    else $error("address released outside reset");
  a_mode_latch: assert property (
    !i_sys_reset_in_n |=> o_ext_prog_mem == !$past(i_nonmask_irq_mode_sel_n)) else $error("mode not captured");
  a_irq_edge: assert property (
    $fell(i_ext_irq_n) && !i_global_irq_mask && i_sys_reset_in_n |-> ##[1:3] o_irq_req)
    else $error("edge did not raise request");
  a_nmi_unmasked: assert property (
    $fell(i_nonmask_irq_mode_sel_n) && i_sys_reset_in_n && $past(i_sys_reset_in_n) |-> ##[1:3] o_nmi_req)
    else $error("nmi not taken");
  c_port_read: cover property (!o_rd_strobe_n && $past(i_core_port));
  c_int_write: cover property (!o_data_oe_n && o_wr_strobe_n);
  c_irq: cover property ($rose(o_irq_req));
endmodule
bind dxbus_top dxbus_asserts u_chk (.*);

// ### test/dxbus_mem.sv
// external memory and port peripheral on the far side of the bus
`timescale 1ns/1ps
module dxbus_mem (
  input  wire logic        i_clock,
  input  wire logic        i_rd_strobe_n,
  input  wire logic        i_wr_strobe_n,
  input  wire logic [11:0] i_addr,
  input  wire logic [15:0] i_data,
  output logic [15:0]      o_data
);
  logic [15:0] mem [16];
  logic [15:0] last_r = 16'h0000;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'h5000 + 16'(i);
  always @(posedge i_clock) begin
    if (!i_wr_strobe_n) mem[i_addr[3:0]] <= i_data;
    if (!i_rd_strobe_n) last_r <= o_data;
  end
  // drive only while read strobe low
  // released bus shows the inverse so a late sample cannot pass by luck
  assign o_data = !i_rd_strobe_n ? mem[i_addr[3:0]] : ~last_r;
endmodule

// ### test/tb.sv
// self-checking bench for the bus and system pin block
`timescale 1ns/1ps
module tb;
  import dxbus_pkg::*;
  logic i_clock = 0, i_rst = 1, i_sys_reset_in_n = 1, i_ext_irq_n = 1, i_nonmask_irq_mode_sel_n = 1;
  logic i_core_rd = 0, i_core_wr = 0, i_core_int_wr = 0, i_core_port = 0, i_global_irq_mask = 0, i_irq_ack = 0;
  logic [2:0] i_core_port_sel = 0;
  logic [11:0] i_core_addr = 0, o_program_counter, o_addr;
  logic [15:0] i_core_wdata = 0, o_core_rdata, i_data, o_data, mem_data;
  logic o_sys_clock_out, o_core_rvalid, o_irq_req, o_nmi_req, o_ext_prog_mem;
  logic o_addr_oe_n, o_data_oe_n, o_wr_strobe_n, o_rd_strobe_n;
  int n_fail = 0, n_compared = 0, cyc = 0;
  assign i_data = o_data_oe_n ? mem_data : o_data;
  dxbus_top u_dut (.*);
  dxbus_mem u_mem (.i_clock(i_clock), .i_rd_strobe_n(o_rd_strobe_n), .i_wr_strobe_n(o_wr_strobe_n),
                   .i_addr(o_addr), .i_data(i_data), .o_data(mem_data));
  initial forever #50 i_clock = ~i_clock;
  task close_out;
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clock) if (++cyc == 2000) begin n_fail++; close_out; end
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clock);
    #5;
  endtask
  task req(input int k, input logic [11:0] a, input logic [15:0] d, input logic p, input logic [2:0] s);
    tick(1);
    {i_core_addr, i_core_wdata, i_core_port, i_core_port_sel} = {a, d, p, s};
    {i_core_rd, i_core_wr, i_core_int_wr} = {k == 1, k == 2, k == 3};
    tick(1);
    {i_core_rd, i_core_wr, i_core_int_wr} = 3'h0;
  endtask
  task t_reset_pin;
    {i_sys_reset_in_n, i_nonmask_irq_mode_sel_n} = 2'h0;
    tick(2);
    chk("ext mem", 16'h1, o_ext_prog_mem);
    chk("pc", 16'h0, o_program_counter);
    chk("addr oe", 16'h1, o_addr_oe_n);
    chk("nmi", 16'h0, o_nmi_req);
    i_nonmask_irq_mode_sel_n = 1;
    tick(2);
    chk("ext mem", 16'h0, o_ext_prog_mem);
    i_sys_reset_in_n = 1;
    tick(2);
    chk("addr oe", 16'h0, o_addr_oe_n);
    chk("pc run", 16'h2, o_program_counter);
  endtask
  task t_mem_and_ports;
    for (int i = 0; i < 8; i++) begin
      req(2, 12'h000, 16'hc3a0 + 16'(i), i[0], 3'(i));
      chk("wr strobe", 16'h0, o_wr_strobe_n);
      chk("wdata", 16'hc3a0 + 16'(i), o_data);
      chk("addr", i[0] ? {9'h1ff, 3'(i)} : 16'h000, o_addr);
      req(1, 12'h000, 16'h0000, 1'b1, 3'(i));
      chk("rd strobe", 16'h0, o_rd_strobe_n);
      chk("addr", {9'h1ff, 3'(i)}, o_addr);
      tick(1);
      chk("rvalid", 16'h1, o_core_rvalid);
      chk("rdata", i[0] ? 16'hc3a0 + 16'(i) : 16'h5008 + 16'(i), o_core_rdata);
      chk("oe idle", 16'h1, o_data_oe_n);
    end
  endtask
  task t_int_write;
    req(3, 12'h00a, 16'h9e17, 1'b0, 3'h0);
    chk("oe int", 16'h0, o_data_oe_n);
    chk("wr strobe", 16'h1, o_wr_strobe_n);
    chk("data int", 16'h9e17, o_data);
    tick(1);
    chk("oe after", 16'h1, o_data_oe_n);
  endtask
  task t_irq;
    int hi;
    {i_global_irq_mask, i_ext_irq_n} = 2'h2;
    tick(3);
    chk("irq masked", 16'h0, o_irq_req);
    {i_global_irq_mask, i_ext_irq_n} = 2'h1;
    tick(1);
    i_ext_irq_n = 0;
    tick(3);
    chk("irq", 16'h1, o_irq_req);
    i_irq_ack = 1;
    tick(1);
    i_irq_ack = 0;
    chk("irq ack", 16'h0, o_irq_req);
    {i_global_irq_mask, i_ext_irq_n, i_nonmask_irq_mode_sel_n} = 3'h6;
    tick(3);
    chk("nmi", 16'h1, o_nmi_req);
    hi = 0;
    for (int i = 0; i < 8; i++) begin
      tick(1);
      hi += int'(o_sys_clock_out === 1'b1);
    end
    chk("clk high", 16'h4, 16'(hi));
  endtask
  initial begin
    tick(5);
    i_rst = 0;
    t_reset_pin;
    t_mem_and_ports;
    t_int_write;
    t_irq;
    close_out;
  end
endmodule
